// >>> rx_cfg_decode.sv
/*
  Turns raw receiver_settings codes into derived quantities:
  sync pattern length in bits, tolerated errors, decrement step in
  half-dB units and decrement rate as a shift.
  Assumes codes come registered from the configuration bank.
*/
`timescale 1ns/1ns
`include "rx_cfg_params.svh"
module rx_cfg_decode (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] sync_length_code,
  input wire logic [1:0] sync_tolerance,
  input wire logic sync_enable,
  input wire logic [2:0] decrement_size,
  input wire logic [2:0] decrement_rate,
  output logic [5:0] sync_bits_r,
  output logic [1:0] max_errors_r,
  output logic [3:0] step_half_db_r,
  output logic rate_is_fast_r,
  output logic [1:0] rate_shift_r
);

  logic [5:0] sync_bits_nxt;
  logic [1:0] max_errors_nxt;
  logic [3:0] step_half_db_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // length is 8 times (code+1); tolerance only matters with matching on
  always_comb begin
    sync_bits_nxt = {1'b0, sync_length_code, 3'h0} + 6'h08;
    max_errors_nxt = sync_enable ? sync_tolerance : 2'h0;
    unique case (decrement_size)
      3'h0: step_half_db_nxt = 4'h1;
      3'h1: step_half_db_nxt = 4'h2;
      3'h2: step_half_db_nxt = 4'h3;
      3'h3: step_half_db_nxt = 4'h4;
      3'h4: step_half_db_nxt = 4'h6;
      3'h5: step_half_db_nxt = 4'h8;
      3'h6: step_half_db_nxt = 4'hA;
      3'h7: step_half_db_nxt = 4'hC;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_bits_r <= `RST_SYNC_BITS;
      max_errors_r <= `RST_ZERO_2;
      step_half_db_r <= `RST_STEP_HALF_DB;
      rate_is_fast_r <= `RST_ZERO_BIT;
      rate_shift_r <= `RST_ZERO_2;
    end else begin
      sync_bits_r <= sync_bits_nxt;
      max_errors_r <= max_errors_nxt;
      step_half_db_r <= step_half_db_nxt;
      rate_is_fast_r <= decrement_rate[2];
      rate_shift_r <= decrement_rate[1:0];
    end
  end

endmodule : rx_cfg_decode

// >>> rx_cfg_host.sv
/*
  Host model that drives the receiver configuration register port.
  Assumes the bank never stalls and answers a read one cycle after rd.
*/
`timescale 1ns/1ns
module rx_cfg_host (
  input wire logic clk_sys,
  input wire logic [7:0] rdata_r,
  output rx_cfg_pkg::reg_req_t req
);
  import rx_cfg_pkg::*;

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial req = '0;

  // one-cycle write strobe; caller idles after the last write of a burst
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input bit raw,
                           output logic [7:0] sent);
    sent = data;
    if (!raw) begin
      if (addr == 8'h11) sent[3:0] = 4'h8;
      if (addr == 8'h12) sent[0] = 1'b0;
      if (addr == 8'h13) sent = 8'h07;
      if (addr == 8'h15 && sent[1] != sent[0]) sent[1:0] = 2'h0;
    end
    @(posedge clk_sys);
    // a careful host never writes the strength byte, only a raw test does
    if (addr == 8'h14 && !raw)
      req <= '0;
    else
      req <= '{addr: addr, wdata: sent, wr: 1'b1, rd: 1'b0};
  endtask : write_reg

  // drop every strobe for one cycle
  task automatic idle();
    @(posedge clk_sys);
    req <= '0;
  endtask : idle

  // read strobe for one cycle, data taken in the cycle after it
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1;
    data = rdata_r;
  endtask : read_reg
endmodule : rx_cfg_host

// >>> rx_cfg_params.svh
/*
  Register offsets, field positions and reset values
  for the receiver configuration bank.
  Assumes byte-wide registers addressed directly by their offsets.
*/
`ifndef RX_CFG_PARAMS_SVH
`define RX_CFG_PARAMS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define OFS_RX_FILTER_BANDWIDTH 8'h10
`define OFS_RX_POLYPHASE_CENTER 8'h11
`define OFS_RX_SYNC_AND_BIT_CONTROL 8'h12
`define OFS_RX_RESERVED_BYTE 8'h13
`define OFS_RX_SIGNAL_STRENGTH 8'h14
`define OFS_RX_OOK_THRESHOLD_CONTROL 8'h15

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_LOWPASS_BW_CODE 4'hA
`define RST_RX_BW_CODE 4'h3
`define RST_POLYPHASE_CENTER_CODE 4'h3
`define RST_POLYPHASE_RESERVED 4'h8
`define RST_SYNC_LENGTH 2'h3
`define RST_RESERVED_BYTE 8'h07
`define RST_ZERO_BIT 1'h0
`define RST_ZERO_2 2'h0
`define RST_ZERO_3 3'h0
`define RST_ZERO_BYTE 8'h00
`define RST_SYNC_BITS 6'h20
`define RST_STEP_HALF_DB 4'h1

// ----------------------------------------
// field positions (low bit of each field)
// ----------------------------------------
`define POS_HIGH_NIBBLE 4
`define POS_POLYPHASE_ENABLE 7
`define POS_BITSYNC_BYPASS 6
`define POS_SYNC_ENABLE 5
`define POS_SYNC_LENGTH 3
`define POS_SYNC_TOLERANCE 1
`define POS_DECREMENT_SIZE 5
`define POS_DECREMENT_RATE 2
`define POS_AVERAGE_CUTOFF 0

`endif

// >>> rx_cfg_pkg.sv
/*
  Types shared by the receiver configuration bank.
  Assumes rx_cfg_params.svh holds every number.
*/
package rx_cfg_pkg;

  // register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // raw receiver setting codes, as stored, handed to the analog and demod logic
  typedef struct packed {
    logic [3:0] lowpass_bw_code;
    logic [3:0] rx_bw_code;
    logic [3:0] polyphase_center_code;
    logic [3:0] polyphase_reserved;
    logic polyphase_enable;
    logic bitsync_bypass;
    logic sync_enable;
    logic [1:0] sync_length_code;
    logic [1:0] sync_tolerance;
    logic sync_reserved;
    logic [7:0] reserved_byte;
    logic [2:0] threshold_decrement_size;
    logic [2:0] threshold_decrement_rate;
    logic [1:0] threshold_average_cutoff;
  } receiver_settings_t;

endpackage : rx_cfg_pkg

// >>> rx_cfg_regs.sv
/*
  Receiver configuration register bank, byte addresses 16 to 21.
  Assumes a simple strobe port on clk_sys; read data one cycle later.
*/
// How it works
// - address 16 bits 7-4 hold lowpass bandwidth code, reset 1010.
// - address 16 bits 3-0 hold receive bandwidth code, reset 0011.
// - address 17 bits 7-4 hold polyphase centre code, reset 0011.
// - address 18 bit 7 enables polyphase filter in OOK receive, reset off.
// - address 18 bit 6 set bypasses bit synchronizer, reset active.
// - address 18 bits 4-3 select sync length 8/16/24/32, reset 11.
// - bit 5 enables sync matching; bits 2-1 give tolerated errors, reset 0.
// - address 20 is read-only signal strength, 0.5 dB per bit; writes ignored.
// - address 21 bits 7-5 select threshold decrement size, reset 000.
// - address 21 bits 4-2 select threshold decrement rate, reset 000.
// - address 21 bits 1-0 select averaging cutoff; 01 and 10 forbidden.
`timescale 1ns/1ns
`include "rx_cfg_params.svh"
module rx_cfg_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire rx_cfg_pkg::reg_req_t req,
  input wire logic [7:0] signal_strength_in,
  output logic [7:0] rdata_r,
  output rx_cfg_pkg::receiver_settings_t settings_r,
  output logic [5:0] sync_bits_r,
  output logic [1:0] max_errors_r,
  output logic [3:0] step_half_db_r,
  output logic rate_is_fast_r,
  output logic [1:0] rate_shift_r
);
  import rx_cfg_pkg::*;

  receiver_settings_t settings_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] signal_strength_r;

  // ----------------------------------------
  // write path
  // ----------------------------------------
  // byte 19 and reserved bits are stored as written; software keeps them
  always_comb begin
    settings_nxt = settings_r;
    if (req.wr) begin
      unique case (req.addr)
        `OFS_RX_FILTER_BANDWIDTH: begin
          settings_nxt.lowpass_bw_code = req.wdata[7:`POS_HIGH_NIBBLE];
          settings_nxt.rx_bw_code = req.wdata[3:0];
        end
        `OFS_RX_POLYPHASE_CENTER: begin
          settings_nxt.polyphase_center_code = req.wdata[7:`POS_HIGH_NIBBLE];
          settings_nxt.polyphase_reserved = req.wdata[3:0];
        end
        `OFS_RX_SYNC_AND_BIT_CONTROL: begin
          settings_nxt.polyphase_enable = req.wdata[`POS_POLYPHASE_ENABLE];
          settings_nxt.bitsync_bypass = req.wdata[`POS_BITSYNC_BYPASS];
          settings_nxt.sync_enable = req.wdata[`POS_SYNC_ENABLE];
          settings_nxt.sync_length_code = req.wdata[`POS_SYNC_LENGTH +: 2];
          settings_nxt.sync_tolerance = req.wdata[`POS_SYNC_TOLERANCE +: 2];
          settings_nxt.sync_reserved = req.wdata[0];
        end
        `OFS_RX_RESERVED_BYTE: begin
          settings_nxt.reserved_byte = req.wdata;
        end
        `OFS_RX_OOK_THRESHOLD_CONTROL: begin
          settings_nxt.threshold_decrement_size = req.wdata[`POS_DECREMENT_SIZE +: 3];
          settings_nxt.threshold_decrement_rate = req.wdata[`POS_DECREMENT_RATE +: 3];
          settings_nxt.threshold_average_cutoff = req.wdata[`POS_AVERAGE_CUTOFF +: 2];
        end
        // signal strength and unmapped addresses: write dropped
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped addresses read as zero; data valid only the cycle after
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_RX_FILTER_BANDWIDTH: rdata_nxt = {settings_r.lowpass_bw_code, settings_r.rx_bw_code};
        `OFS_RX_POLYPHASE_CENTER: rdata_nxt = {settings_r.polyphase_center_code, settings_r.polyphase_reserved};
        `OFS_RX_SYNC_AND_BIT_CONTROL: rdata_nxt = {settings_r.polyphase_enable, settings_r.bitsync_bypass,
                                                   settings_r.sync_enable, settings_r.sync_length_code,
                                                   settings_r.sync_tolerance, settings_r.sync_reserved};
        `OFS_RX_RESERVED_BYTE: rdata_nxt = settings_r.reserved_byte;
        `OFS_RX_SIGNAL_STRENGTH: rdata_nxt = signal_strength_r;
        `OFS_RX_OOK_THRESHOLD_CONTROL: rdata_nxt = {settings_r.threshold_decrement_size,
                                                    settings_r.threshold_decrement_rate,
                                                    settings_r.threshold_average_cutoff};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // strength is sampled from the measurement logic on the same clock
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      settings_r.lowpass_bw_code <= `RST_LOWPASS_BW_CODE;
      settings_r.rx_bw_code <= `RST_RX_BW_CODE;
      settings_r.polyphase_center_code <= `RST_POLYPHASE_CENTER_CODE;
      settings_r.polyphase_reserved <= `RST_POLYPHASE_RESERVED;
      settings_r.polyphase_enable <= `RST_ZERO_BIT;
      settings_r.bitsync_bypass <= `RST_ZERO_BIT;
      settings_r.sync_enable <= `RST_ZERO_BIT;
      settings_r.sync_length_code <= `RST_SYNC_LENGTH;
      settings_r.sync_tolerance <= `RST_ZERO_2;
      settings_r.sync_reserved <= `RST_ZERO_BIT;
      settings_r.reserved_byte <= `RST_RESERVED_BYTE;
      settings_r.threshold_decrement_size <= `RST_ZERO_3;
      settings_r.threshold_decrement_rate <= `RST_ZERO_3;
      settings_r.threshold_average_cutoff <= `RST_ZERO_2;
      rdata_r <= `RST_ZERO_BYTE;
      signal_strength_r <= `RST_ZERO_BYTE;
    end else begin
      settings_r <= settings_nxt;
      rdata_r <= rdata_nxt;
      signal_strength_r <= signal_strength_in;
    end
  end

  // ----------------------------------------
  // derived quantities
  // ----------------------------------------
  rx_cfg_decode u_decode (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sync_length_code(settings_r.sync_length_code),
    .sync_tolerance(settings_r.sync_tolerance),
    .sync_enable(settings_r.sync_enable),
    .decrement_size(settings_r.threshold_decrement_size),
    .decrement_rate(settings_r.threshold_decrement_rate),
    .sync_bits_r(sync_bits_r),
    .max_errors_r(max_errors_r),
    .step_half_db_r(step_half_db_r),
    .rate_is_fast_r(rate_is_fast_r),
    .rate_shift_r(rate_shift_r)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_ctl;
    req.wr && req.addr == `OFS_RX_SYNC_AND_BIT_CONTROL;
  endsequence
  // decoded outputs trail the stored codes by one more edge
  sequence s_ctl_settled;
    s_write_ctl ##1 1'b1;
  endsequence

  a_lowpass_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_FILTER_BANDWIDTH |=> settings_r.lowpass_bw_code == $past(req.wdata[7:4]))
    else $error("lowpass code not stored");
  a_rxbw_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_FILTER_BANDWIDTH |=> settings_r.rx_bw_code == $past(req.wdata[3:0]))
    else $error("bandwidth code not stored");
  a_center_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_POLYPHASE_CENTER |=> settings_r.polyphase_center_code == $past(req.wdata[7:4]))
    else $error("centre code not stored");
  a_poly_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_ctl |=> settings_r.polyphase_enable == $past(req.wdata[7]))
    else $error("polyphase enable wrong");
  a_bitsync_bypass: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_ctl |=> settings_r.bitsync_bypass == $past(req.wdata[6]))
    else $error("bit sync bypass wrong");
  a_sync_length: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ctl_settled |=> sync_bits_r == 6'h08 * ({4'h0, $past(req.wdata[4:3], 2)} + 6'h01))
    else $error("sync length wrong");
  a_sync_tolerance: assert property (@(posedge clk_sys) disable iff (!rstn)
    !settings_r.sync_enable ##1 $stable(settings_r.sync_enable) |-> max_errors_r == 2'h0)
    else $error("errors tolerated with matching off");
  a_strength_ro: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_SIGNAL_STRENGTH |=> $stable(settings_r))
    else $error("strength write changed settings");
  a_strength_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.rd && req.addr == `OFS_RX_SIGNAL_STRENGTH |=> rdata_r == $past(signal_strength_r))
    else $error("strength read wrong");
  a_step_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL
    |=> settings_r.threshold_decrement_size == $past(req.wdata[7:5]))
    else $error("decrement size wrong");
  a_rate_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL
    |=> ##1 rate_is_fast_r == $past(req.wdata[4], 2))
    else $error("decrement rate wrong");
  a_cutoff_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL
    |=> settings_r.threshold_average_cutoff == $past(req.wdata[1:0]))
    else $error("cutoff wrong");

  // ----------------------------------------
  // read-back, hold, decode and reset checks
  // ----------------------------------------
  // the OOK write and the reads of bytes 16, 17, 18 and 21 that checks below start from
  sequence s_write_ook;
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL;
  endsequence
  sequence s_ook_settled;
    s_write_ook ##1 1'b1;
  endsequence
  sequence s_read_filter;
    req.rd && req.addr == `OFS_RX_FILTER_BANDWIDTH;
  endsequence
  sequence s_read_center;
    req.rd && req.addr == `OFS_RX_POLYPHASE_CENTER;
  endsequence
  sequence s_read_ctl;
    req.rd && req.addr == `OFS_RX_SYNC_AND_BIT_CONTROL;
  endsequence
  sequence s_read_ook;
    req.rd && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL;
  endsequence

  // read data shows each stored field at its own bit position
  a_filter_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_filter |=> rdata_r[7:4] == $past(settings_r.lowpass_bw_code))
    else $error("lowpass code read wrong");
  a_rxbw_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_filter |=> rdata_r[3:0] == $past(settings_r.rx_bw_code))
    else $error("bandwidth code read wrong");
  a_center_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_center |=> rdata_r[7:4] == $past(settings_r.polyphase_center_code))
    else $error("centre code read wrong");
  a_enable_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ctl |=> rdata_r[7] == $past(settings_r.polyphase_enable))
    else $error("polyphase enable read wrong");
  a_bypass_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ctl |=> rdata_r[6] == $past(settings_r.bitsync_bypass))
    else $error("bit sync bypass read wrong");
  a_length_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ctl |=> rdata_r[4:3] == $past(settings_r.sync_length_code))
    else $error("sync length read wrong");
  a_tolerance_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ctl |=> rdata_r[5] == $past(settings_r.sync_enable) && rdata_r[2:1] == $past(settings_r.sync_tolerance))
    else $error("sync matching read wrong");
  a_step_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ook |=> rdata_r[7:5] == $past(settings_r.threshold_decrement_size))
    else $error("decrement size read wrong");
  a_rate_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ook |=> rdata_r[4:2] == $past(settings_r.threshold_decrement_rate))
    else $error("decrement rate read wrong");
  a_cutoff_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_read_ook |=> rdata_r[1:0] == $past(settings_r.threshold_average_cutoff))
    else $error("cutoff read wrong");
  // stale read data would look like a second answer
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    !req.rd |=> rdata_r == 8'h00)
    else $error("read data outside its cycle");

  // fields that the write checks above leave out, and holding between writes
  a_sync_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_ctl |=> settings_r.sync_enable == $past(req.wdata[5]))
    else $error("sync enable not stored");
  a_tolerance_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_ctl |=> settings_r.sync_tolerance == $past(req.wdata[2:1]))
    else $error("tolerance not stored");
  a_rate_field: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_write_ook |=> settings_r.threshold_decrement_rate == $past(req.wdata[4:2]))
    else $error("rate code not stored");
  a_hold_filter: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(req.wr && req.addr == `OFS_RX_FILTER_BANDWIDTH) |=> $stable({settings_r.lowpass_bw_code, settings_r.rx_bw_code}))
    else $error("bandwidth byte changed without a write");
  a_hold_ook: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL) |=> $stable({settings_r.threshold_decrement_size,
      settings_r.threshold_decrement_rate, settings_r.threshold_average_cutoff}))
    else $error("threshold byte changed without a write");

  // decoded values, taken at the ends and the bend of the step table
  a_errors_enabled: assert property (@(posedge clk_sys) disable iff (!rstn)
    settings_r.sync_enable |=> max_errors_r == $past(settings_r.sync_tolerance))
    else $error("tolerated errors wrong");
  a_step_smallest: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL && req.wdata[7:5] == 3'h0 ##1 1'b1
    |=> step_half_db_r == 4'h1)
    else $error("half dB step wrong");
  a_step_middle: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL && req.wdata[7:5] == 3'h4 ##1 1'b1
    |=> step_half_db_r == 4'h6)
    else $error("three dB step wrong");
  a_step_largest: assert property (@(posedge clk_sys) disable iff (!rstn)
    req.wr && req.addr == `OFS_RX_OOK_THRESHOLD_CONTROL && req.wdata[7:5] == 3'h7 ##1 1'b1
    |=> step_half_db_r == 4'hC)
    else $error("six dB step wrong");
  a_rate_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ook_settled |=> rate_shift_r == $past(req.wdata[3:2], 2))
    else $error("rate shift wrong");
  a_strength_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
    rstn |=> signal_strength_r == $past(signal_strength_in))
    else $error("strength not sampled");

  // power-on values, seen on the edge after any reset edge
  a_reset_filter: assert property (@(posedge clk_sys)
    !rstn |=> settings_r.lowpass_bw_code == `RST_LOWPASS_BW_CODE && settings_r.rx_bw_code == `RST_RX_BW_CODE)
    else $error("bandwidth byte reset wrong");
  a_reset_center: assert property (@(posedge clk_sys)
    !rstn |=> settings_r.polyphase_center_code == `RST_POLYPHASE_CENTER_CODE)
    else $error("centre code reset wrong");
  a_reset_control: assert property (@(posedge clk_sys)
    !rstn |=> settings_r.polyphase_enable == `RST_ZERO_BIT && settings_r.bitsync_bypass == `RST_ZERO_BIT
      && settings_r.sync_enable == `RST_ZERO_BIT && settings_r.sync_length_code == `RST_SYNC_LENGTH
      && settings_r.sync_tolerance == `RST_ZERO_2)
    else $error("control byte reset wrong");
  a_reset_ook: assert property (@(posedge clk_sys)
    !rstn |=> settings_r.threshold_decrement_size == `RST_ZERO_3 && settings_r.threshold_decrement_rate == `RST_ZERO_3
      && settings_r.threshold_average_cutoff == `RST_ZERO_2)
    else $error("threshold byte reset wrong");
  a_reset_decode: assert property (@(posedge clk_sys)
    !rstn |=> sync_bits_r == `RST_SYNC_BITS && step_half_db_r == `RST_STEP_HALF_DB && max_errors_r == `RST_ZERO_2)
    else $error("decoded values reset wrong");

endmodule : rx_cfg_regs

// >>> testbench.sv
/*
  Self-checking bench for the receiver configuration bank.
  Assumes rx_cfg_host drives the register port and a byte model predicts it.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
  import rx_cfg_pkg::*;

  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] signal_strength_in = 8'h00;
  reg_req_t req;
  logic [7:0] rdata_r;
  receiver_settings_t settings_r;
  logic [5:0] sync_bits_r;
  logic [1:0] max_errors_r;
  logic [3:0] step_half_db_r;
  logic rate_is_fast_r;
  logic [1:0] rate_shift_r;
  int model[8];
  int steps[8] = '{1, 2, 3, 4, 6, 8, 10, 12};
  int seed = 6302;
  int fail_count = 0;
  int checked = 0;

  always #2 clk_sys = ~clk_sys;

  rx_cfg_regs rx_cfg_regs_i (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .req(req),
    .signal_strength_in(signal_strength_in),
    .rdata_r(rdata_r),
    .settings_r(settings_r),
    .sync_bits_r(sync_bits_r),
    .max_errors_r(max_errors_r),
    .step_half_db_r(step_half_db_r),
    .rate_is_fast_r(rate_is_fast_r),
    .rate_shift_r(rate_shift_r)
  );

  rx_cfg_host rx_cfg_host_i (
    .clk_sys(clk_sys),
    .rdata_r(rdata_r),
    .req(req)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // synchronous reset held four edges; model returns to power-on bytes
  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    model = '{8'hA3, 8'h38, 8'h18, 8'h07, 0, 8'h00, 0, 0};
    // look at outputs only once the release edge has settled
    #1;
  endtask : do_reset

  // compares stored fields, decoded outputs and every read-back byte
  task automatic check_all(input string name);
    logic [7:0] got;
    int e;
    `CHK(settings_r, ({model[0][7:0], model[1][7:0], model[2][7:0], model[3][7:0], model[5][7:0]}))
    `CHK(sync_bits_r, 6'(8 * (model[2][4:3] + 1)))
    `CHK(max_errors_r, (model[2][5] ? model[2][2:1] : 2'h0))
    `CHK(step_half_db_r, 4'(steps[model[5][7:5]]))
    `CHK(({rate_is_fast_r, rate_shift_r}), model[5][4:2])
    for (int a = 16; a < 23; a++) begin
      rx_cfg_host_i.read_reg(8'(a), got);
      e = (a == 20) ? int'(signal_strength_in) : (a == 22) ? 0 : model[a - 16];
      `CHK(got, 8'(e))
    end
    // read data must not linger past its one cycle
    @(posedge clk_sys);
    #1;
    `CHK(rdata_r, 8'h00)
    $display("test %s done", name);
  endtask : check_all

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  // every wait is fixed, so this only trips on a stuck simulation
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] s0;
    logic [7:0] s1;
    logic [7:0] a;
    do_reset();
    check_all("reset values");
    for (int i = 0; i < 48; i++) begin
      @(posedge clk_sys);
      signal_strength_in <= 8'($random(seed));
      if (i == 24) begin
        do_reset();
        check_all("mid-run reset");
      end
      if (i < 8) begin
        // walk every sync length, tolerance, step and rate code back to back
        rx_cfg_host_i.write_reg(8'h12, {i[2], i[0], i[2], i[1:0], i[1:0], 1'b0}, 1'b0, s0);
        rx_cfg_host_i.write_reg(8'h15, {i[2:0], i[2:0], i[0], i[0]}, 1'b0, s1);
        model[2] = s0;
        model[5] = s1;
      end else begin
        repeat (2) begin
          a = 8'h10 + 8'($unsigned($random(seed)) % 7);
          // strength byte and unmapped byte are written raw and must be ignored
          rx_cfg_host_i.write_reg(a, 8'($random(seed)), (a == 8'h14 || a == 8'h16), s0);
          if (a != 8'h14 && a != 8'h16) model[a - 8'h10] = s0;
        end
      end
      rx_cfg_host_i.idle();
      @(posedge clk_sys);
      #1;
      check_all($sformatf("pass %0d", i));
    end
    give_verdict();
  end
endmodule : testbench
